// ===== hdl/cca_top.sv
// Register-driven setup of converter clocks, regulators and aux ADC.
// Assumes register requests are synchronous to mclk_i, one per cycle.
// Function
// [R01] Pick aux12 full scale from two bits
// [R02] Aux12 output is full scale times code/1024
// [R03] Three-level pin sets regulator enables
// [R04] Register disables regulators except core
// [R05] External 1.8 V needs regulators off
// [R06] Write 0x53: multiplier source, reference, N=3
// [R07] Multiply by programmed M plus one
// [R08] DAC clock is input times mult over N
// [R09] Host enables then pulses multiplier reset
// [R10] Lock flag reported in bit 7
// [R11] Both data buses single rate after reset
// [R12] Receive doubler doubles input clock
// [R13] Transmit doubler doubles DAC clock, selectable
// [R14] Host enables doublers above 15 MHz
// [R15] Host bypasses stabilizer below 75 MHz
// [R16] Host selects then resets receive doubler
// [R17] Host writes doubler offset 0x55
// [R18] Write 0x08 sets drive level three
// [R19] Host selects temperature channel, starts sample
// [R20] Result split high byte, low nibble
// [R21] Conversion starts next aux tick, 20-34 cycles
// [R22] Temperature channel scaled 0.2 K per code
// [R23] Host waits for lock before use
module cca_top
  import cca_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire cca_req_s req_i,
  output logic [7:0] rdata_o,
  input wire cca_pin_e regulator_enable_pin_i,
  output logic [4:0] regulator_on_o,
  input wire logic aux12_reference_select_i,
  input wire logic aux12_range_select_i,
  input wire logic [11:0] aux12_code_i,
  input wire logic [11:0] housekeeping_supply_mv_i,
  output logic [14:0] aux12_vout_mv_o,
  input wire logic [17:0] main_clock_khz_i,
  output logic [25:0] converter_tx_clock_khz_o,
  output logic [26:0] transmit_clock_output_khz_o,
  output logic [18:0] converter_rx_clock_khz_o,
  output logic multiplier_locked_o,
  output logic dcs_bypass_o,
  output logic [2:0] rx_drive_level_o,
  output logic [7:0] rx_doubler_offset_o,
  output logic ddr_mode_o,
  input wire logic [11:0] aux_analog_code_i,
  input wire logic [12:0] temperature_voltage_dk_i,
  output logic adc_busy_o
);
  // Writable registers
  logic [7:0] rx_src_r, rx_ofs_r, mul_en_r, reg_dis_r;
  logic [7:0] drive_r, dcs_r, dac_clk_r, mul_fac_r;
  logic [7:0] mul_rst_r, aux_ch_r, aux_en_r, temp_en_r;
  logic [11:0] adc_res_r;   // Last conversion result
  logic locked_r;           // Multiplier lock flag
  logic wr_ch;              // Write to channel register
  assign wr_ch = req_i.wr && req_i.addr == ADR_AUX_CH;

  // Register writes, one concern per register group
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_src_r <= RST_ZERO;
      rx_ofs_r <= RST_RX_OFS;
      mul_en_r <= RST_ZERO;
      reg_dis_r <= RST_ZERO;
      drive_r <= RST_ZERO;
      dcs_r <= RST_ZERO;
      dac_clk_r <= RST_ZERO;
      mul_fac_r <= RST_ZERO;
      mul_rst_r <= RST_ZERO;
      aux_ch_r <= RST_ZERO;
      aux_en_r <= RST_ZERO;
      temp_en_r <= RST_ZERO;
    end else if (req_i.wr) begin
      unique case (req_i.addr)
        ADR_RX_SRC: rx_src_r <= req_i.data;
        ADR_RX_OFS: rx_ofs_r <= req_i.data;
        ADR_MUL_EN: mul_en_r <= req_i.data;
        ADR_REG_DIS: reg_dis_r <= req_i.data;
        ADR_DRIVE: drive_r <= req_i.data;
        ADR_DCS: dcs_r <= req_i.data;
        ADR_DAC_CLK: dac_clk_r <= req_i.data;
        // Lock bit is read-only, only M is stored
        ADR_MUL_FAC: mul_fac_r <= {1'b0, req_i.data[6:0]};
        ADR_MUL_RST: mul_rst_r <= req_i.data;
        ADR_AUX_CH: aux_ch_r <= req_i.data;
        ADR_AUX_EN: aux_en_r <= req_i.data;
        ADR_TEMP_EN: temp_en_r <= req_i.data;
        default: ;  // Unmapped writes are dropped
      endcase
    end
  end

  // Read mux, registered so data appears one cycle after rd
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= RST_ZERO;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        ADR_RX_SRC: rdata_o <= rx_src_r;
        ADR_RX_OFS: rdata_o <= rx_ofs_r;
        ADR_MUL_EN: rdata_o <= mul_en_r;
        ADR_REG_DIS: rdata_o <= reg_dis_r;
        ADR_DRIVE: rdata_o <= drive_r;
        ADR_DCS: rdata_o <= dcs_r;
        ADR_DAC_CLK: rdata_o <= dac_clk_r;
        // [R10] lock in bit 7
        ADR_MUL_FAC: rdata_o <= {locked_r, mul_fac_r[6:0]};
        ADR_MUL_RST: rdata_o <= mul_rst_r;
        ADR_AUX_CH: rdata_o <= aux_ch_r;
        // [R20] high byte then low nibble
        ADR_AUX_HI: rdata_o <= adc_res_r[11:4];
        ADR_AUX_LO: rdata_o <= {adc_res_r[3:0], 4'h0};
        ADR_AUX_EN: rdata_o <= aux_en_r;
        ADR_TEMP_EN: rdata_o <= temp_en_r;
        default: rdata_o <= RST_ZERO;  // Unmapped reads zero
      endcase
    end
  end

  // Regulator enables; bit 0 is the core digital one
  logic [4:0] reg_on_nxt;
  always_comb begin
    // [R03] three-level pin decode
    unique case (regulator_enable_pin_i)
      CCA_PIN_HIGH: reg_on_nxt = 5'h1F;
      CCA_PIN_MID: reg_on_nxt = 5'h01;
      default: reg_on_nxt = 5'h00;  // Low, or an illegal code
    endcase
    // [R04] register cannot touch core
    reg_on_nxt[4:1] = reg_on_nxt[4:1] & ~reg_dis_r[4:1];
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) regulator_on_o <= 5'h00;
    else regulator_on_o <= reg_on_nxt;
  end

  // Aux12 full scale and output level
  logic [12:0] vfs_mv;
  logic [18:0] supply_x;
  logic [24:0] vout_x;
  always_comb begin
    supply_x = housekeeping_supply_mv_i * RATIO_NUM;
    // [R01] full scale pick
    unique case ({aux12_reference_select_i, aux12_range_select_i})
      2'b00: vfs_mv = {1'b0, housekeeping_supply_mv_i};
      2'b01: vfs_mv = 13'(supply_x / RATIO_DEN);
      2'b10: vfs_mv = FS_3V3_MV;
      default: vfs_mv = FS_1V8_MV;
    endcase
    vout_x = vfs_mv * aux12_code_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    // [R02] scale by code over 1024
    if (!rst_n_i) aux12_vout_mv_o <= 15'h0000;
    else aux12_vout_mv_o <= vout_x[CODE_SHIFT +: 15];
  end

  // Clock plan: multiplier, divider and doublers
  logic [7:0] mult;
  logic [3:0] ndiv;
  logic [25:0] dll_khz;
  logic dll_src;
  // [R07] effective multiplication M plus one
  assign mult = {1'b0, mul_fac_r[6:0]} + 8'h01;
  assign ndiv = (dac_clk_r[3:0] == 4'h0) ? 4'h1 : dac_clk_r[3:0];
  // [R06] source from multiplier with reference on
  assign dll_src = dac_clk_r[B_SRC] && dac_clk_r[B_REF];
  assign dll_khz = 26'(main_clock_khz_i * mult);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_tx_clock_khz_o <= 26'h0;
      transmit_clock_output_khz_o <= 27'h0;
      converter_rx_clock_khz_o <= 19'h0;
    end else begin
      // [R08] input times mult over N
      converter_tx_clock_khz_o <= dll_src ?
        26'(dll_khz / ndiv) : {8'h00, main_clock_khz_i};
      // [R13] transmit doubler optional
      transmit_clock_output_khz_o <= dac_clk_r[B_TX_DBL] ?
        {converter_tx_clock_khz_o, 1'b0} :
        {1'b0, converter_tx_clock_khz_o};
      // [R12] receive doubler, idle while held in reset
      converter_rx_clock_khz_o <=
        (rx_src_r[B_RX_DBL] && !rx_src_r[B_RX_RST]) ?
        {main_clock_khz_i, 1'b0} : {1'b0, main_clock_khz_i};
    end
  end

  // Static controls from registers; bus rate tied to single
  always_comb begin
    dcs_bypass_o = dcs_r[B_DCS];
    // [R18] drive level is field plus one
    rx_drive_level_o = {1'b0, drive_r[3:2]} + 3'h1;
    rx_doubler_offset_o = rx_ofs_r;
    // [R11] single rate bus; no rate select is held here
    ddr_mode_o = 1'b0;
  end

  // Multiplier lock sequencing
  typedef enum logic [1:0] {
    L_IDLE, L_HOLD, L_WAIT, L_LOCK
  } cca_lock_e;
  cca_lock_e lock_st_r;
  logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_r;
  logic mul_on;
  assign mul_on = mul_en_r[B_EN] && dac_clk_r[B_REF];
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_st_r <= L_IDLE;
      lock_cnt_r <= '0;
    end else if (!mul_on) begin
      lock_st_r <= L_IDLE;  // Disabled multiplier drops lock
    end else if (mul_rst_r[B_MRST]) begin
      lock_st_r <= L_HOLD;  // Reset held high
    end else begin
      unique case (lock_st_r)
        L_IDLE: lock_st_r <= L_IDLE;
        L_HOLD: begin
          lock_st_r <= L_WAIT;
          lock_cnt_r <= '0;
        end
        L_WAIT: begin
          lock_cnt_r <= lock_cnt_r + 1'b1;
          if (lock_cnt_r == LOCK_CYC - 1) lock_st_r <= L_LOCK;
        end
        L_LOCK: lock_st_r <= L_LOCK;
      endcase
    end
  end
  // [R10] flag follows lock state
  assign locked_r = (lock_st_r == L_LOCK);
  assign multiplier_locked_o = locked_r;

  // Aux ADC clock divider: tick once per R main clocks
  logic [2:0] aux_div_r;
  logic aux_tick;
  assign aux_tick = (aux_div_r == 3'h0);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) aux_div_r <= 3'h0;
    else if (!aux_en_r[B_EN] || aux_tick)
      aux_div_r <= (aux_en_r[2:0] == 3'h0) ? 3'h0 : aux_en_r[2:0] - 3'h1;
    else aux_div_r <= aux_div_r - 3'h1;
  end

  // Aux ADC conversion sequencer
  typedef enum logic [1:0] {A_IDLE, A_ARM, A_CONV} cca_adc_e;
  cca_adc_e adc_st_r;
  logic [5:0] conv_cnt_r, conv_len;
  logic [11:0] sample;
  always_comb begin
    unique case (temp_en_r[1:0])
      2'h0: conv_len = CONV_0;
      2'h1: conv_len = CONV_1;
      2'h2: conv_len = CONV_2;
      default: conv_len = CONV_3;
    endcase
    // [R22] deci-kelvin halved gives 0.2 K per code
    sample = (aux_ch_r[2:0] == CH_TEMP) ?
      (temp_en_r[B_EN] ? 12'(temperature_voltage_dk_i >> 1) : 12'h000)
      : aux_analog_code_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adc_st_r <= A_IDLE;
      conv_cnt_r <= 6'h00;
      adc_res_r <= 12'h000;
    end else if (!aux_en_r[B_EN]) begin
      adc_st_r <= A_IDLE;
    end else if (wr_ch) begin
      adc_st_r <= A_ARM;  // A new write restarts conversion
    end else begin
      unique case (adc_st_r)
        A_IDLE: adc_st_r <= A_IDLE;
        // [R21] start on next aux tick
        A_ARM: if (aux_tick) begin
          adc_st_r <= A_CONV;
          conv_cnt_r <= conv_len - 6'h01;
        end
        // [R21] run the selected cycle count
        A_CONV: if (aux_tick) begin
          if (conv_cnt_r == 6'h01) begin
            adc_st_r <= A_IDLE;
            adc_res_r <= sample;
          end else conv_cnt_r <= conv_cnt_r - 6'h01;
        end
      endcase
    end
  end
  assign adc_busy_o = (adc_st_r != A_IDLE);

  // [R21] busy length for the bound check
  // Saturates so a slow aux clock cannot wrap it
  logic [7:0] busy_cyc_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cyc_r <= 8'h00;
    else if (wr_ch || !adc_busy_o) busy_cyc_r <= 8'h00;
    else if (busy_cyc_r != 8'hFF) busy_cyc_r <= busy_cyc_r + 8'h01;
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_core_pin_mid: assert property ( // [R03]
    regulator_enable_pin_i == CCA_PIN_MID |=> regulator_on_o == 5'h01)
    else $error("mid pin must enable core only");
  a_core_no_dis: assert property ( // [R04]
    regulator_enable_pin_i == CCA_PIN_HIGH |=> regulator_on_o[0])
    else $error("core regulator disabled by register");
  a_full_scale_3v3: assert property ( // [R01]
    {aux12_reference_select_i, aux12_range_select_i} == 2'b10
    && aux12_code_i == 12'h400 |=> aux12_vout_mv_o == 15'(FS_3V3_MV))
    else $error("3.3 V full scale wrong");
  a_mult_plus_one: assert property ( // [R07]
    req_i.wr && req_i.addr == ADR_MUL_FAC && req_i.data == 8'h09
    |=> mult == 8'h0A)
    else $error("multiplication not M plus one");
  a_lock_bit_read: assert property ( // [R10]
    req_i.rd && req_i.addr == ADR_MUL_FAC
    |=> rdata_o[B_LOCK] == $past(locked_r))
    else $error("lock bit not in bit 7");
  a_lock_needs_time: assert property ( // [R10]
    $rose(locked_r) |-> $past(lock_st_r, 1) == L_WAIT
    && !$past(mul_rst_r[B_MRST], 1))
    else $error("lock raised without wait");
  a_adc_split: assert property ( // [R20]
    req_i.rd && req_i.addr == ADR_AUX_LO
    |=> rdata_o == {$past(adc_res_r[3:0]), 4'h0})
    else $error("low result nibble misplaced");
  a_conv_bounds: assert property ( // [R21]
    $fell(adc_busy_o) && aux_en_r[B_EN] && aux_en_r[2:0] <= 3'h1
    && !$past(wr_ch) |-> $past(busy_cyc_r) >= 8'(CONV_0 - 6'h01)
    && $past(busy_cyc_r) <= 8'(CONV_3 - 6'h01))
    else $error("conversion outside 20 to 34 cycles");
  a_drive_level: assert property ( // [R18]
    req_i.wr && req_i.addr == ADR_DRIVE && req_i.data == 8'h08
    |=> rx_drive_level_o == 3'h3)
    else $error("drive level not three");
  a_sdr_mode: assert property ( // [R11]
    !ddr_mode_o)
    else $error("bus left single rate");
  c_lock_seen: cover property (
    lock_st_r == L_WAIT ##1 lock_st_r == L_LOCK);
  c_conv_done: cover property (
    adc_st_r == A_CONV ##1 adc_st_r == A_IDLE);
  c_rx_double: cover property (
    converter_rx_clock_khz_o == {main_clock_khz_i, 1'b0}
    && main_clock_khz_i != 18'h0);
endmodule : cca_top

// ===== hdl/cca_pkg.sv
// Package for the converter clock and auxiliary setup block.
// Assumes one 100 MHz clock and byte-wide register accesses.
package cca_pkg;
  // Register offsets
  localparam logic [7:0] ADR_RX_SRC = 8'h39;
  localparam logic [7:0] ADR_RX_OFS = 8'h3B;
  localparam logic [7:0] ADR_MUL_EN = 8'h60;
  localparam logic [7:0] ADR_REG_DIS = 8'h61;
  localparam logic [7:0] ADR_DRIVE = 8'h63;
  localparam logic [7:0] ADR_DCS = 8'h66;
  localparam logic [7:0] ADR_DAC_CLK = 8'h71;
  localparam logic [7:0] ADR_MUL_FAC = 8'h72;
  localparam logic [7:0] ADR_MUL_RST = 8'h75;
  localparam logic [7:0] ADR_AUX_CH = 8'h77;
  localparam logic [7:0] ADR_AUX_HI = 8'h78;
  localparam logic [7:0] ADR_AUX_LO = 8'h79;
  localparam logic [7:0] ADR_AUX_EN = 8'h7A;
  localparam logic [7:0] ADR_TEMP_EN = 8'h7B;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RX_OFS = 8'h4D;
  // Field positions
  localparam int B_EN = 7;       // enable bits in 0x60/0x7A/0x7B
  localparam int B_RX_DBL = 1;   // 0x39 doubler select
  localparam int B_RX_RST = 7;   // 0x39 doubler reset
  localparam int B_DCS = 2;      // 0x66 stabilizer bypass
  localparam int B_SRC = 6;      // 0x71 clock from multiplier
  localparam int B_REF = 4;      // 0x71 reference enable
  localparam int B_TX_DBL = 5;   // 0x71 transmit doubler
  localparam int B_MRST = 3;     // 0x75 multiplier reset
  localparam int B_LOCK = 7;     // 0x72 lock flag
  // Analog figures in millivolts and scale factors
  localparam logic [12:0] FS_3V3_MV = 13'h0CE4;
  localparam logic [12:0] FS_1V8_MV = 13'h0708;
  localparam logic [6:0] RATIO_NUM = 7'h36;  // 0.54 as 54/100
  localparam logic [6:0] RATIO_DEN = 7'h64;
  localparam int CODE_SHIFT = 10;            // divide by 1024
  localparam logic [2:0] CH_TEMP = 3'h3;
  // Conversion lengths in aux clock cycles
  localparam logic [5:0] CONV_0 = 6'h14;     // 20
  localparam logic [5:0] CONV_1 = 6'h18;
  localparam logic [5:0] CONV_2 = 6'h1C;
  localparam logic [5:0] CONV_3 = 6'h22;     // 34
  // Multiplier lock time
  localparam int CLK_MHZ = 100;
  localparam int LOCK_NS = 2000;
  localparam int LOCK_CYC = (LOCK_NS * CLK_MHZ + 999) / 1000;
  // Regulator enable pin levels
  typedef enum logic [1:0] {
    CCA_PIN_LOW, CCA_PIN_MID, CCA_PIN_HIGH
  } cca_pin_e;
  // Register request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } cca_req_s;
endpackage : cca_pkg

// ===== test/cca_host.sv
// Host model that programs the setup registers one byte at a time.
// Assumes the bench calls its tasks; fields change 1 ns after an edge.
module cca_host
  import cca_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output cca_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus never shows a stale value
  initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, data: 8'hFF};

  // One-cycle request; fields scrambled once the edge has taken it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    req_o = '{wr: w, rd: !w, addr: a, data: d};
    @(posedge mclk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : xfer

  // Register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  // Register read; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = rdata_i;
  endtask : rd

  task automatic regs_off();
    wr(ADR_REG_DIS, 8'h1E);
  endtask : regs_off

  task automatic dll_setup();
    wr(ADR_MUL_EN, 8'h80);
    wr(ADR_DAC_CLK, 8'h53);
    wr(ADR_MUL_FAC, 8'h09);
    wr(ADR_MUL_RST, 8'h08);
    wr(ADR_MUL_RST, 8'h00);
  endtask : dll_setup

  // poll lock flag, bounded so a dead lock cannot hang
  task automatic wait_lock(output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < 40 && d[7] !== 1'b1; i++) begin
      repeat (10) @(posedge mclk_i);
      rd(ADR_MUL_FAC, d);
    end
  endtask : wait_lock

  // receive doubler bring-up below 75 MHz
  task automatic dbl_setup();
    wr(ADR_RX_SRC, 8'h02);
    wr(ADR_DCS, 8'h04);
    wr(ADR_RX_OFS, 8'h55);
    wr(ADR_RX_SRC, 8'h82);
    wr(ADR_RX_SRC, 8'h02);
    wr(ADR_DRIVE, 8'h08);
  endtask : dbl_setup

  task automatic temp_read();
    wr(ADR_AUX_CH, 8'h03);
    wr(ADR_AUX_EN, 8'h80);
    wr(ADR_TEMP_EN, 8'h80);
    wr(ADR_AUX_CH, 8'h83);
  endtask : temp_read
endmodule : cca_host

// ===== test/tb_top.sv
// Self-checking bench for the converter clock and aux setup block.
// Assumes the host model in cca_host drives every register request.
module tb_top
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i, rst_n_i, ref_sel, rng_sel, locked, dcs, ddr, busy;
  cca_req_s req;
  cca_pin_e pin;
  logic [7:0] rdata, ofs, v;
  logic [4:0] reg_on;
  logic [11:0] code, sup, an_code;
  logic [14:0] vout;
  logic [17:0] mclk_khz;
  logic [25:0] tx_khz;
  logic [26:0] txo_khz;
  logic [18:0] rx_khz;
  logic [2:0] drive;
  logic [12:0] temp_dk;
  int errors = 0;
  int checked = 0;
  // Expected tables for pin levels and full-scale modes
  logic [4:0] pin_exp [3] = '{5'h00, 5'h01, 5'h1F};
  logic [14:0] fs_exp [4] = '{15'h0BB8, 15'h0654, 15'h0CE4, 15'h0708};

  cca_host u_host (.mclk_i(mclk_i), .rdata_i(rdata), .req_o(req));

  cca_top u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
    .regulator_enable_pin_i(pin), .regulator_on_o(reg_on),
    .aux12_reference_select_i(ref_sel), .aux12_range_select_i(rng_sel),
    .aux12_code_i(code), .housekeeping_supply_mv_i(sup),
    .aux12_vout_mv_o(vout), .main_clock_khz_i(mclk_khz),
    .converter_tx_clock_khz_o(tx_khz),
    .transmit_clock_output_khz_o(txo_khz),
    .converter_rx_clock_khz_o(rx_khz), .multiplier_locked_o(locked),
    .dcs_bypass_o(dcs), .rx_drive_level_o(drive),
    .rx_doubler_offset_o(ofs), .ddr_mode_o(ddr),
    .aux_analog_code_i(an_code), .temperature_voltage_dk_i(temp_dk),
    .adc_busy_o(busy)
  );

  // 100 MHz clock
  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // Let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  // Read one register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk(v, e, "register read");
  endtask : rdchk

  // Verdict and end of run
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // Watchdog: tests need about 420 cycles
  initial begin
    #300000;
    errors++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    pin = CCA_PIN_LOW;
    {ref_sel, rng_sel} = 2'h0;
    code = 12'h400;
    sup = 12'hBB8;
    mclk_khz = 18'h07530;
    an_code = 12'hABC;
    temp_dk = 13'h0BB8;
    tick(5);
    chk(ddr, 1'b0, "single rate");
    chk(drive, 3'h1, "drive reset");
    chk(ofs, 8'h4D, "offset reset");
    rst_n_i = 1'b1;
    u_host.wr(ADR_AUX_HI, 8'hFF);
    rdchk(ADR_AUX_HI, 8'h00);
    rdchk(8'h50, 8'h00);
    $display("test reset done");
    // Pin decode, then register overrides
    for (int i = 0; i < 3; i++) begin
      pin = cca_pin_e'(i);
      tick(2);
      chk(reg_on, pin_exp[i], "pin decode");
    end
    u_host.regs_off();
    tick(1);
    chk(reg_on, 5'h01, "regulators off");
    u_host.wr(ADR_REG_DIS, 8'h1F);
    tick(1);
    chk(reg_on, 5'h01, "core stays on");
    rdchk(ADR_REG_DIS, 8'h1F);
    $display("test regulators done");
    // Full-scale selection at code 1024, then half of 1.8 V
    for (int i = 0; i < 4; i++) begin
      {ref_sel, rng_sel} = i[1:0];
      tick(2);
      chk(vout, fs_exp[i], "full scale");
    end
    code = 12'h200;
    tick(2);
    chk(vout, 15'h0384, "half scale");
    $display("test aux dac done");
    // Multiplier bring-up
    u_host.dll_setup();
    tick(150);
    chk(locked, 1'b0, "early lock");
    u_host.wait_lock(v);
    chk(v, 8'h89, "lock readback");
    chk(tx_khz, 26'h186A0, "dac clock");
    chk(txo_khz, 27'h186A0, "tx clock plain");
    u_host.wr(ADR_DAC_CLK, 8'h73);
    tick(3);
    chk(txo_khz, 27'h30D40, "tx clock doubled");
    $display("test multiplier done");
    // Receive doubler
    chk(rx_khz, 19'h07530, "rx clock plain");
    u_host.dbl_setup();
    tick(2);
    chk(rx_khz, 19'h0EA60, "rx clock doubled");
    chk(dcs, 1'b1, "stabilizer bypass");
    chk(ofs, 8'h55, "doubler offset");
    chk(drive, 3'h3, "drive level");
    rdchk(ADR_RX_OFS, 8'h55);
    $display("test doubler done");
    // Temperature, shortest conversion
    u_host.temp_read();
    tick(1);
    chk(busy, 1'b1, "busy start");
    tick(16);
    chk(busy, 1'b1, "busy mid");
    tick(6);
    chk(busy, 1'b0, "busy end");
    rdchk(ADR_AUX_HI, 8'h5D);
    rdchk(ADR_AUX_LO, 8'hC0);
    // Plain channel, longest conversion
    u_host.wr(ADR_TEMP_EN, 8'h83);
    u_host.wr(ADR_AUX_CH, 8'h00);
    tick(30);
    chk(busy, 1'b1, "long busy");
    tick(7);
    chk(busy, 1'b0, "long end");
    rdchk(ADR_AUX_HI, 8'hAB);
    rdchk(ADR_AUX_LO, 8'hC0);
    // Aux clock halved, sensor off, 24-cycle setting
    u_host.wr(ADR_AUX_EN, 8'h82);
    u_host.wr(ADR_TEMP_EN, 8'h01);
    u_host.wr(ADR_AUX_CH, 8'h03);
    tick(44);
    chk(busy, 1'b1, "divided busy");
    tick(6);
    chk(busy, 1'b0, "divided end");
    rdchk(ADR_AUX_HI, 8'h00);
    rdchk(ADR_AUX_LO, 8'h00);
    $display("test aux adc done");
    // Reset in mid-run brings back the defaults
    rst_n_i = 1'b0;
    tick(2);
    chk(locked, 1'b0, "lock after reset");
    chk(ddr, 1'b0, "single rate again");
    chk(ofs, 8'h4D, "offset default");
    rst_n_i = 1'b1;
    rdchk(ADR_MUL_FAC, 8'h00);
    $display("test mid reset done");
    results();
  end
endmodule : tb_top
